// *** verilog/gpio_cfg.svh ***
// Purpose: Constants for the dual shared GPIO port block
// Assumes: Register indices become byte addresses times four
// Notes:   Definitions only
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_P1_DATA 16'hFFDA
`define IDX_P2_DATA 16'hFFDB
`define IDX_P1_DIR  16'hFFEA
`define IDX_P2_DIR  16'hFFEB

// ----------------------------------------------------------------
// Reset values and read constants
// ----------------------------------------------------------------
`define RST_DATA    8'h00
`define RST_DIR     8'h00
`define DIR_RD_VAL  8'hFF

// ----------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Segment select decode
// ----------------------------------------------------------------
`define P1_GPIO_SEL 2'h0
`define P2_GPIO_SEL 3'h0

`endif

// *** verilog/gpio_pkg.sv ***
// Purpose: Types for the dual shared GPIO port block
// Assumes: Nothing beyond the cfg header
// Notes:   Power mode codes come from the outside sequencer
package gpio_pkg;

  // --------------------------------------------------------------
  // Operating modes
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ACTIVE    = 3'h0,
    MODE_SUBACTIVE = 3'h1,
    MODE_SLEEP     = 3'h2,
    MODE_SUBSLEEP  = 3'h3,
    MODE_WATCH     = 3'h4,
    MODE_STANDBY   = 3'h5
  } power_mode_e;

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE    = 3'h0,
    SEL_P1_DATA = 3'h1,
    SEL_P2_DATA = 3'h2,
    SEL_P1_DIR  = 3'h3,
    SEL_P2_DIR  = 3'h4
  } reg_sel_e;

  // Registered drive of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pad_s;

endpackage

// *** verilog/dual_gpio_port.sv ***
// Purpose: Two 8-bit GPIO ports shared with LCD segment outputs
// Assumes: AXI4-Lite register access, pins synchronous to clock_i
// Notes:   LCD control and power sequencing live outside
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "gpio_cfg.svh"

module dual_gpio_port
  import gpio_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0]   awaddr_i,
  input  wire logic                awvalid_i,
  output logic                     awready_o,
  input  wire logic [31:0]         wdata_i,
  input  wire logic [3:0]          wstrb_i,
  input  wire logic                wvalid_i,
  output logic                     wready_o,
  output logic [1:0]               bresp_o,
  output logic                     bvalid_o,
  input  wire logic                bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   araddr_i,
  input  wire logic                arvalid_i,
  output logic                     arready_o,
  output logic [31:0]              rdata_o,
  output logic [1:0]               rresp_o,
  output logic                     rvalid_o,
  input  wire logic                rready_i,
  // LCD controller and mode sequencer
  input  wire logic [3:0]          segment_select_field_i,
  input  wire logic [2*PORT_W-1:0] lcd_segment_output_i,
  input  power_mode_e              power_mode_i,
  // First port pins
  input  wire logic [PORT_W-1:0]   first_port_pin_i,
  output logic [PORT_W-1:0]        first_port_pin_o,
  output logic [PORT_W-1:0]        first_port_pin_oe_o,
  // Second port pins
  input  wire logic [PORT_W-1:0]   second_port_pin_i,
  output logic [PORT_W-1:0]        second_port_pin_o,
  output logic [PORT_W-1:0]        second_port_pin_oe_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PORT_W < 1 || PORT_W > 8 || ADDR_W < 18 || ADDR_W > 32) begin : g_bad
    $error("PORT_W must be 1 to 8 and ADDR_W 18 to 32");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] p1_data_ff;
  logic [PORT_W-1:0] p2_data_ff;
  logic [PORT_W-1:0] p1_dir_ff;
  logic [PORT_W-1:0] p2_dir_ff;
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [PORT_W-1:0] wbyte_ff;
  logic              wlane_ff;
  logic              awready_ff;
  logic              wready_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;
  pad_s              p1_pad_ff;
  pad_s              p2_pad_ff;
  logic              p1_gpio;
  logic              p2_gpio;
  logic              commit;
  logic              rd_take;
  reg_sel_e          wsel;
  reg_sel_e          rsel;
  logic [PORT_W-1:0] p1_rd;
  logic [PORT_W-1:0] p2_rd;
  logic              functional;
  logic              standby;
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'({`IDX_P1_DATA, 2'h0})) return SEL_P1_DATA;
    if (a == ADDR_W'({`IDX_P2_DATA, 2'h0})) return SEL_P2_DATA;
    if (a == ADDR_W'({`IDX_P1_DIR, 2'h0})) return SEL_P1_DIR;
    if (a == ADDR_W'({`IDX_P2_DIR, 2'h0})) return SEL_P2_DIR;
    return SEL_NONE;
  endfunction
  assign wsel       = decode(waddr_ff);
  assign rsel       = decode(araddr_i);
  assign commit     = aw_held_ff && w_held_ff && !bvalid_ff;
  assign rd_take    = arvalid_i && arready_ff;
  assign p1_gpio    = segment_select_field_i[3:2] == `P1_GPIO_SEL;
  assign p2_gpio    = segment_select_field_i[3:1] == `P2_GPIO_SEL;
  assign functional = power_mode_i inside {MODE_ACTIVE, MODE_SUBACTIVE};
  assign standby    = power_mode_i == MODE_STANDBY;
  // ----------------------------------------------------------------
  // Read path, per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PORT_W; i++) begin : g_rd
    assign p1_rd[i] = p1_dir_ff[i] ? p1_data_ff[i]
                                   : first_port_pin_i[i];
    assign p2_rd[i] = p2_dir_ff[i] ? p2_data_ff[i]
                                   : second_port_pin_i[i];
  end

  // ----------------------------------------------------------------
  // Write address and data capture
  // ----------------------------------------------------------------
  // Either channel may come first; each is held until both meet
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      waddr_ff   <= '0;
    end else if (awvalid_i && awready_ff) begin
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
      waddr_ff   <= awaddr_i;
    end else if (commit) begin
      aw_held_ff <= 1'b0;
    end else if (!aw_held_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b0;
      wbyte_ff  <= '0;
      wlane_ff  <= 1'b0;
    end else if (wvalid_i && wready_ff) begin
      w_held_ff <= 1'b1;
      wready_ff <= 1'b0;
      wbyte_ff  <= wdata_i[PORT_W-1:0];
      wlane_ff  <= wstrb_i[0];
    end else if (commit) begin
      w_held_ff <= 1'b0;
    end else if (!w_held_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else if (commit) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bready_i) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Latches store regardless of direction or segment use
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      p1_data_ff <= PORT_W'(`RST_DATA);
      p2_data_ff <= PORT_W'(`RST_DATA);
    end else if (commit && wlane_ff) begin
      if (wsel == SEL_P1_DATA) p1_data_ff <= wbyte_ff;
      if (wsel == SEL_P2_DATA) p2_data_ff <= wbyte_ff;
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      p1_dir_ff <= PORT_W'(`RST_DIR);
      p2_dir_ff <= PORT_W'(`RST_DIR);
    end else if (commit && wlane_ff) begin
      if (wsel == SEL_P1_DIR) p1_dir_ff <= wbyte_ff;
      if (wsel == SEL_P2_DIR) p2_dir_ff <= wbyte_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `RESP_OKAY;
      rdata_ff   <= 32'h0;
    end else if (rd_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= `RESP_OKAY;
      rdata_ff   <= 32'h0;
      unique case (rsel)
        SEL_P1_DATA: rdata_ff <= 32'(p1_rd);
        SEL_P2_DATA: rdata_ff <= 32'(p2_rd);
        SEL_P1_DIR:  rdata_ff <= 32'(`DIR_RD_VAL);
        SEL_P2_DIR:  rdata_ff <= 32'(`DIR_RD_VAL);
        SEL_NONE:    rresp_ff <= `RESP_SLVERR;
      endcase
    end else if (rvalid_ff && rready_i) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Sleep, subsleep and watch freeze the last drive on purpose
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      p1_pad_ff <= '0;
    end else if (standby) begin
      p1_pad_ff.oe <= '0;
    end else if (functional) begin
      if (p1_gpio) begin
        p1_pad_ff.out <= 8'(p1_data_ff);
        p1_pad_ff.oe  <= 8'(p1_dir_ff);
      end else begin
        p1_pad_ff.out <= 8'(lcd_segment_output_i[PORT_W-1:0]);
        p1_pad_ff.oe  <= 8'hFF;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      p2_pad_ff <= '0;
    end else if (standby) begin
      p2_pad_ff.oe <= '0;
    end else if (functional) begin
      if (p2_gpio) begin
        p2_pad_ff.out <= 8'(p2_data_ff);
        p2_pad_ff.oe  <= 8'(p2_dir_ff);
      end else begin
        p2_pad_ff.out <= 8'(lcd_segment_output_i[2*PORT_W-1:PORT_W]);
        p2_pad_ff.oe  <= 8'hFF;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready_o            = awready_ff;
  assign wready_o             = wready_ff;
  assign bvalid_o             = bvalid_ff;
  assign bresp_o              = bresp_ff;
  assign arready_o            = arready_ff;
  assign rvalid_o             = rvalid_ff;
  assign rresp_o              = rresp_ff;
  assign rdata_o              = rdata_ff;
  assign first_port_pin_o     = p1_pad_ff.out[PORT_W-1:0];
  assign first_port_pin_oe_o  = p1_pad_ff.oe[PORT_W-1:0];
  assign second_port_pin_o    = p2_pad_ff.out[PORT_W-1:0];
  assign second_port_pin_oe_o = p2_pad_ff.oe[PORT_W-1:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_P1_RESET_DATA: assert property (
    $rose(rst_n_i) |-> p1_data_ff == '0 && first_port_pin_oe_o == '0)
    else $error("first latch or drive not cleared by reset");
  AST_P1_RESET_DIR: assert property (
    $rose(rst_n_i) |-> p1_dir_ff == '0)
    else $error("first direction not cleared by reset");
  AST_P1_DIR_READ: assert property (
    rd_take && rsel == SEL_P1_DIR |=> rdata_o[7:0] == 8'hFF)
    else $error("first direction read not all ones");
  AST_P2_DIR_READ: assert property (
    rd_take && rsel == SEL_P2_DIR |=> rvalid_o && rdata_o[7:0] == 8'hFF)
    else $error("second direction read not all ones");
  AST_P1_READ_MIX: assert property (
    rd_take && rsel == SEL_P1_DATA |=>
      rdata_o[PORT_W-1:0] == (($past(p1_dir_ff) & $past(p1_data_ff)) |
                       (~$past(p1_dir_ff) & $past(first_port_pin_i))))
    else $error("first port read mux wrong");
  AST_P2_READ_MIX: assert property (
    rd_take && rsel == SEL_P2_DATA |=>
      rdata_o[PORT_W-1:0] == (($past(p2_dir_ff) & $past(p2_data_ff)) |
                       (~$past(p2_dir_ff) & $past(second_port_pin_i))))
    else $error("second port read mux wrong");
  AST_P1_GPIO: assert property (
    functional && p1_gpio |=> first_port_pin_oe_o == $past(p1_dir_ff)
      && first_port_pin_o == $past(p1_data_ff))
    else $error("first port gpio drive wrong");
  AST_P1_SEG: assert property (
    functional && !standby && !p1_gpio |=> &first_port_pin_oe_o &&
      first_port_pin_o == $past(lcd_segment_output_i[PORT_W-1:0]))
    else $error("first port segment drive wrong");
  AST_P2_SEG: assert property (
    functional && !p2_gpio |=> &second_port_pin_oe_o)
    else $error("second port segment not driven");
  AST_STANDBY_HIZ: assert property (
    standby |=> second_port_pin_oe_o == '0 && first_port_pin_oe_o == '0)
    else $error("pins driven in standby");
  AST_RETAIN: assert property (
    !functional && !standby |=> $stable(first_port_pin_o) &&
      $stable(first_port_pin_oe_o))
    else $error("first port drive changed while held");
  AST_WRITE_STORE: assert property (
    commit && wlane_ff && wsel == SEL_P2_DATA |=>
      p2_data_ff == $past(wbyte_ff))
    else $error("second latch write lost");
  COV_WRITE: cover property (commit && wsel == SEL_P1_DIR);
  COV_READ_PIN: cover property (rd_take && rsel == SEL_P2_DATA);
  COV_SEG_MODE: cover property (functional && !p1_gpio && p2_gpio);
  COV_HOLD: cover property (power_mode_i == MODE_WATCH);
endmodule

// *** test/pin_partner.sv ***
// Purpose: External circuitry on one 8-bit shared port
// Assumes: Outside source is weak, the block's driver wins
// Notes:   Wire level is fed back to the block's pin input
`timescale 1ns/100ps

module pin_partner
  import gpio_pkg::*;
#(
  parameter int W = 8
) (
  // Block side of the pins
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_i,
  // Outside source level
  input  wire logic [W-1:0] ext_i,
  // Resolved wire level
  output logic [W-1:0]      pin_o
);
  // Weak outside source, so no contention while the block drives
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the dual shared GPIO port
// Assumes: Pads load one edge after a register commit
// Notes:   Reset check first, then table rows, latch, bus, power, reset cases
`timescale 1ns/100ps
`include "gpio_cfg.svh"

module tb_top
  import gpio_pkg::*;
;
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  num_errors++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [19:0] A_D1 = 20'({`IDX_P1_DATA, 2'b00});
  localparam logic [19:0] A_D2 = 20'({`IDX_P2_DATA, 2'b00});
  localparam logic [19:0] A_R1 = 20'({`IDX_P1_DIR, 2'b00});
  localparam logic [19:0] A_R2 = 20'({`IDX_P2_DIR, 2'b00});
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [19:0] awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0, field = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] lcd_segment_output = '0;
  logic [7:0]  ext1 = '0, ext2 = '0, pin1_i, pin2_i, pin1_o, pin2_o, oe1, oe2;
  power_mode_e pmode = MODE_ACTIVE;
  int          num_errors = 0, check_count = 0;

  typedef struct packed {
    logic [3:0]  fld;
    logic [7:0]  dir, dat, ext;
    logic [15:0] sg;
    logic [7:0]  rd1, rd2, oe1, out1, oe2, out2;
  } row_s;
  row_s rows [6] = '{
    '{4'h0, 8'hFF, 8'hA5, 8'h3C, 16'h0000,
      8'hA5, 8'hA5, 8'hFF, 8'hA5, 8'hFF, 8'hA5},
    '{4'h0, 8'h0F, 8'h5A, 8'hC3, 16'h0000,
      8'hCA, 8'hCA, 8'h0F, 8'h0A, 8'h0F, 8'h0A},
    '{4'h2, 8'hF0, 8'h96, 8'h69, 16'h1234,
      8'h99, 8'h92, 8'hF0, 8'h90, 8'hFF, 8'h12},
    '{4'h1, 8'h00, 8'hFF, 8'h81, 16'h0000,
      8'h81, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00},
    '{4'h4, 8'h00, 8'h00, 8'h55, 16'hABCD,
      8'hCD, 8'hAB, 8'hFF, 8'hCD, 8'hFF, 8'hAB},
    '{4'h8, 8'hFF, 8'h3C, 8'h55, 16'h0F0F,
      8'h3C, 8'h3C, 8'hFF, 8'h0F, 8'hFF, 8'h0F}
  };
  power_mode_e hold_m [3] = '{MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH};

  always #25 clock_i = ~clock_i;

  dual_gpio_port u_dual_gpio_port (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
    .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
    .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
    .segment_select_field_i(field), .lcd_segment_output_i(lcd_segment_output),
    .power_mode_i(pmode),
    .first_port_pin_i(pin1_i), .first_port_pin_o(pin1_o),
    .first_port_pin_oe_o(oe1),
    .second_port_pin_i(pin2_i), .second_port_pin_o(pin2_o),
    .second_port_pin_oe_o(oe2)
  );
  pin_partner u_pin_partner_1 (.out_i(pin1_o), .oe_i(oe1), .ext_i(ext1),
                               .pin_o(pin1_i));
  pin_partner u_pin_partner_2 (.out_i(pin2_o), .oe_i(oe2), .ext_i(ext2),
                               .pin_o(pin2_i));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [19:0] a, input logic [7:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge clock_i);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock_i);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge clock_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd_chk(input logic [19:0] a, input logic [31:0] ex,
                        input logic [1:0] er);
    @(posedge clock_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rresp", er, rresp)
    `CHK("rdata", ex, rdata)
  endtask

  task automatic chk_pins(input logic [7:0] eo1, eu1, eo2, eu2);
    repeat (3) @(posedge clock_i);
    `CHK("oe1", eo1, oe1)
    `CHK("out1", eu1, pin1_o & oe1)
    `CHK("oe2", eo2, oe2)
    `CHK("out2", eu2, pin2_o & oe2)
  endtask

  task automatic reset_check;
    chk_pins(8'h00, 8'h00, 8'h00, 8'h00);
    rd_chk(A_R1, 32'h0000_00FF, `RESP_OKAY);
    rd_chk(A_R2, 32'h0000_00FF, `RESP_OKAY);
    axi_wr(A_R1, 8'hFF, 4'h1, `RESP_OKAY);
    axi_wr(A_R2, 8'hFF, 4'h1, `RESP_OKAY);
    rd_chk(A_D1, 32'h0, `RESP_OKAY);
    rd_chk(A_D2, 32'h0, `RESP_OKAY);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    reset_check();
    foreach (rows[i]) begin
      @(posedge clock_i);
      field <= rows[i].fld;
      lcd_segment_output   <= rows[i].sg;
      ext1  <= rows[i].ext;
      ext2  <= rows[i].ext;
      axi_wr(A_R1, rows[i].dir, 4'h1, `RESP_OKAY);
      axi_wr(A_R2, rows[i].dir, 4'h1, `RESP_OKAY);
      axi_wr(A_D1, rows[i].dat, 4'h1, `RESP_OKAY);
      axi_wr(A_D2, rows[i].dat, 4'h1, `RESP_OKAY);
      chk_pins(rows[i].oe1, rows[i].out1, rows[i].oe2, rows[i].out2);
      rd_chk(A_D1, {24'h0, rows[i].rd1}, `RESP_OKAY);
      rd_chk(A_D2, {24'h0, rows[i].rd2}, `RESP_OKAY);
    end
    // Latch stored while the pins serve the segment driver
    axi_wr(A_D1, 8'h77, 4'h1, `RESP_OKAY);
    chk_pins(8'hFF, 8'h0F, 8'hFF, 8'h0F);
    @(posedge clock_i);
    field <= 4'h0;
    chk_pins(8'hFF, 8'h77, 8'hFF, 8'h3C);
    axi_wr(A_D1, 8'hEE, 4'h0, `RESP_OKAY);
    rd_chk(A_D1, 32'h77, `RESP_OKAY);
    axi_wr(20'h00010, 8'h11, 4'h1, `RESP_SLVERR);
    rd_chk(20'h00010, 32'h0, `RESP_SLVERR);
    // Held modes ignore new latch values, standby floats
    foreach (hold_m[i]) begin
      @(posedge clock_i);
      pmode <= hold_m[i];
      axi_wr(A_D1, 8'h20 + 8'(i), 4'h1, `RESP_OKAY);
      chk_pins(8'hFF, 8'h77, 8'hFF, 8'h3C);
    end
    @(posedge clock_i);
    pmode <= MODE_STANDBY;
    chk_pins(8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge clock_i);
    pmode <= MODE_SUBACTIVE;
    chk_pins(8'hFF, 8'h22, 8'hFF, 8'h3C);
    @(posedge clock_i);
    pmode   <= MODE_ACTIVE;
    rst_n_i <= 1'b0;
    chk_pins(8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    reset_check();
    end_of_test();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    end_of_test();
  end
endmodule
